// File: src/data_ram_guard_regs.vh
`ifndef DATA_RAM_GUARD_REGS_VH
`define DATA_RAM_GUARD_REGS_VH

// Register byte offsets on the AXI4-Lite slave.
`define OFF_BUS_CONTROL 4'h0
`define OFF_MEM_CONFIG 4'h4
`define OFF_STATUS 4'h8
`define OFF_FAULT_ADDR 4'hC

// Field positions.
`define BIT_USER_RAM_WP 0
`define BIT_SUPV_VEC_WP 1
`define BIT_BIG_ENDIAN 0
`define BIT_ST_TYPE_FAULT 0
`define BIT_ST_UNIMP_FAULT 1

// Reset values.
`define RST_BUS_CONTROL 32'h00000000
`define RST_MEM_CONFIG 32'h00000000

// Address map of the on-chip RAM.
`define RAM_TOP 32'h000003FF
`define VEC_TOP 32'h0000003F
`define RAM_WORDS 256
`define RAM_AW 8

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: src/ram_write_protect.v
`timescale 1ns/1ps
`include "data_ram_guard_regs.vh"

// Pure decode of the protection state for one write.
module ram_write_protect (
  input wire [31:0] addr,
  input wire user_mode,
  input wire supervisor_vector_write_protect,
  input wire user_ram_write_protect,
  output wire protected_write
);
  wire in_vec;
  assign in_vec = (addr <= `VEC_TOP);
  // Low area: user always blocked, supervisor only by its own bit.
  // Upper area: supervisor always allowed, user blocked by its bit.
  assign protected_write = in_vec ?
    (user_mode | supervisor_vector_write_protect) :
    (user_mode & user_ram_write_protect);
endmodule // ram_write_protect

// File: src/byte_order.v
`timescale 1ns/1ps

// Swaps byte lanes of a word and its strobes when big-endian is selected.
module byte_order (
  input wire big_endian,
  input wire [31:0] data_in,
  input wire [3:0] strobe_in,
  output wire [31:0] data_out,
  output wire [3:0] strobe_out
);
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lane
      assign data_out[8*i+7:8*i] = big_endian ?
        data_in[8*(3-i)+7:8*(3-i)] : data_in[8*i+7:8*i];
      assign strobe_out[i] = big_endian ? strobe_in[3-i] : strobe_in[i];
    end
  endgenerate
endmodule // byte_order

// File: src/internal_data_ram_guard.v
// Overview of operation
// - Addresses 0 to 3FF hex are decoded as the 1 Kbyte on-chip RAM.
// - Loads and stores in that range finish on the RAM, no external bus.
// - An instruction fetch into that range raises the unimplemented fault.
// - RAM accesses never use the data cache; cacheability is ignored.
// - RAM byte order follows the default big-endian bit.
// - The word at address zero holds the cached NMI vector only.
// - Reads of every RAM location are allowed in both modes.
// - User writes to the lowest 64 bytes are always protected.
// - The vector protect bit also protects that area from supervisor.
// - Supervisor writes above the lowest 64 bytes are always accepted.
// - The user protect bit protects 40 to 3FF hex from user writes.
// - A write to a protected location raises the fault_a fault.
// - User or supervisor comes from the mode flag in the process controls.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "data_ram_guard_regs.vh"

module internal_data_ram_guard (
  input wire aclk,
  input wire aresetn,
  // Core request.
  input wire req_valid,
  input wire req_write,
  input wire req_fetch,
  input wire [31:0] req_addr,
  input wire [3:0] req_strobe,
  input wire [31:0] req_wdata,
  input wire req_cacheable,
  input wire process_controls_user_mode,
  output reg rsp_valid,
  output reg [31:0] rsp_rdata,
  output reg fault_a,
  output reg unimplemented_operation_fault,
  // Routing toward the external bus and data cache.
  output wire ext_req_valid,
  output wire dcache_req_valid,
  output wire ext_req_cacheable,
  // AXI4-Lite register slave.
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  reg [31:0] ram [0:`RAM_WORDS-1];
  reg [31:0] bus_control_register;
  reg [31:0] default_memory_config_register;
  reg [1:0] fault_status;
  reg [31:0] fault_addr;
  reg [3:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  wire in_ram;
  wire do_fetch_fault;
  wire protected_write;
  wire do_write_fault;
  wire ram_write;
  wire default_big_endian_bit;
  wire [31:0] wdata_ordered;
  wire [3:0] strobe_ordered;
  wire [31:0] rdata_ordered;
  wire [`RAM_AW-1:0] word_index;
  reg [31:0] ram_word;
  wire aw_go;
  wire w_go;
  wire reg_write;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;

  function [31:0] merge;
    input [31:0] old_value;
    input [31:0] new_value;
    input [3:0] strobe;
    integer k;
    begin
      merge = old_value;
      for (k = 0; k < 4; k = k + 1) begin
        if (strobe[k]) begin
          merge[8*k+:8] = new_value[8*k+:8];
        end
      end
    end
  endfunction

  assign in_ram = (req_addr <= `RAM_TOP);
  assign word_index = req_addr[`RAM_AW+1:2];
  assign default_big_endian_bit =
    default_memory_config_register[`BIT_BIG_ENDIAN];

  // Anything that hits the RAM is kept off the bus and out of the cache,
  // and the cacheable hint is dropped for it.
  assign ext_req_valid = req_valid & ~in_ram;
  assign dcache_req_valid = req_valid & ~in_ram & req_cacheable;
  assign ext_req_cacheable = req_cacheable & ~in_ram;

  assign do_fetch_fault = req_valid & in_ram & req_fetch;

  ram_write_protect u_protect (
    .addr(req_addr),
    .user_mode(process_controls_user_mode),
    .supervisor_vector_write_protect(
      bus_control_register[`BIT_SUPV_VEC_WP]),
    .user_ram_write_protect(bus_control_register[`BIT_USER_RAM_WP]),
    .protected_write(protected_write)
  );

  // Word zero is the NMI vector slot; it falls inside the low area, so it
  // shares that area's protection rather than a separate lock.
  assign do_write_fault = req_valid & in_ram & ~req_fetch & req_write &
    protected_write;
  assign ram_write = req_valid & in_ram & ~req_fetch & req_write &
    ~protected_write;

  byte_order u_wr_order (
    .big_endian(default_big_endian_bit),
    .data_in(req_wdata),
    .strobe_in(req_strobe),
    .data_out(wdata_ordered),
    .strobe_out(strobe_ordered)
  );

  always @* begin
    ram_word = ram[word_index];
  end

  byte_order u_rd_order (
    .big_endian(default_big_endian_bit),
    .data_in(ram_word),
    .strobe_in(4'h0),
    .data_out(rdata_ordered),
    .strobe_out()
  );

  // The RAM has no reset; software must initialise it before use.
  always @(posedge aclk) begin
    if (ram_write) begin
      ram[word_index] <= merge(ram_word, wdata_ordered, strobe_ordered);
    end
  end

  // Reads are granted in either mode whatever the protect bits say.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 32'h00000000;
      fault_a <= 1'b0;
      unimplemented_operation_fault <= 1'b0;
    end else begin
      rsp_valid <= req_valid & in_ram;
      fault_a <= do_write_fault;
      unimplemented_operation_fault <= do_fetch_fault;
      if (req_valid & in_ram & ~req_write & ~req_fetch) begin
        rsp_rdata <= rdata_ordered;
      end
    end
  end

  // AXI4-Lite write path: address and data are caught in either order.
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign aw_go = s_axi_awvalid & s_axi_awready;
  assign w_go = s_axi_wvalid & s_axi_wready;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data = w_held ? w_data : s_axi_wdata;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb;
  assign reg_write = (aw_held | aw_go) & (w_held | w_go) & ~s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (reg_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (wr_addr)
          `OFF_BUS_CONTROL, `OFF_MEM_CONFIG, `OFF_STATUS: begin
            s_axi_bresp <= `RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `RESP_SLVERR;
          end
        endcase
      end else begin
        if (aw_go) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_go) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Control registers and sticky fault status; a new fault wins over a
  // clear written in the same cycle so no event is lost.
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_control_register <= `RST_BUS_CONTROL;
      default_memory_config_register <= `RST_MEM_CONFIG;
      fault_status <= 2'h0;
      fault_addr <= 32'h00000000;
    end else begin
      if (reg_write & (wr_addr == `OFF_BUS_CONTROL)) begin
        bus_control_register <= merge(bus_control_register, wr_data,
          wr_strb) & 32'h00000003;
      end
      if (reg_write & (wr_addr == `OFF_MEM_CONFIG)) begin
        default_memory_config_register <=
          merge(default_memory_config_register, wr_data, wr_strb) &
          32'h00000001;
      end
      if (reg_write & (wr_addr == `OFF_STATUS) & wr_strb[0]) begin
        fault_status <= (fault_status & ~wr_data[1:0]) |
          {do_fetch_fault, do_write_fault};
      end else begin
        fault_status <= fault_status | {do_fetch_fault, do_write_fault};
      end
      if (do_write_fault | do_fetch_fault) begin
        fault_addr <= req_addr;
      end
    end
  end

  // AXI4-Lite read path: one read at a time, answered one cycle later.
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFF_BUS_CONTROL: begin
            s_axi_rdata <= bus_control_register;
          end
          `OFF_MEM_CONFIG: begin
            s_axi_rdata <= default_memory_config_register;
          end
          `OFF_STATUS: begin
            s_axi_rdata <= {30'h00000000, fault_status};
          end
          `OFF_FAULT_ADDR: begin
            s_axi_rdata <= fault_addr;
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // internal_data_ram_guard

// File: tb/guard_monitor.sv
`timescale 1ns/1ps
module guard_monitor (
  input wire aclk,
  input wire aresetn,
  input wire req_valid,
  input wire req_write,
  input wire req_fetch,
  input wire [31:0] req_addr,
  input wire req_cacheable,
  input wire process_controls_user_mode,
  input wire rsp_valid,
  input wire fault_a,
  input wire unimplemented_operation_fault,
  input wire ext_req_valid,
  input wire dcache_req_valid,
  input wire ext_req_cacheable
);
  wire ram = req_addr <= 32'h3FF;
  wire low = req_addr <= 32'h3F;
  wire fe = req_valid && req_fetch && ram;
  wire wr = req_valid && req_write && !req_fetch && ram;
  wire um = process_controls_user_mode;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ram_route: assert property (
    req_valid && ram |-> !ext_req_valid ##1 rsp_valid)
    else $error("RAM request not served locally");
  a_ext_route: assert property (
    req_valid && !ram |-> ext_req_valid && dcache_req_valid == req_cacheable)
    else $error("outside request not routed out");
  a_no_cache: assert property (
    ram |-> !dcache_req_valid && !ext_req_cacheable)
    else $error("RAM address marked cacheable");
  a_fetch_fault: assert property (
    fe |=> unimplemented_operation_fault && !fault_a)
    else $error("fetch in RAM not refused");
  a_user_low: assert property (
    wr && um && low |=> fault_a)
    else $error("user write to low area accepted");
  a_supv_high: assert property (
    wr && !um && !low |=> !fault_a)
    else $error("supervisor write above low area refused");
  a_read_free: assert property (
    req_valid && !req_write && !req_fetch |=> !fault_a)
    else $error("load raised a write fault");
  a_fault_cause: assert property (
    fault_a || unimplemented_operation_fault |-> $past(wr) || $past(fe))
    else $error("fault without a cause");
endmodule // guard_monitor

bind internal_data_ram_guard guard_monitor guard_monitor_i (.*);

// File: tb/core_model.sv
`timescale 1ns/1ps
module core_model (
  input wire aclk,
  output reg req_valid = 1'b0,
  output reg req_write = 1'b0,
  output reg req_fetch = 1'b0,
  output reg [31:0] req_addr = 32'h0,
  output reg [3:0] req_strobe = 4'hF,
  output reg [31:0] req_wdata = 32'h0,
  output reg req_cacheable = 1'b0,
  output reg process_controls_user_mode = 1'b0,
  input wire rsp_valid,
  input wire [31:0] rsp_rdata,
  input wire fault_a,
  input wire unimplemented_operation_fault,
  input wire ext_req_valid
);
  // One request per call, then one idle cycle; the answer is sampled late.
  task access(input [1:0] op, input [31:0] a, input [31:0] d,
      input u, input c, output [3:0] o, output [31:0] rd);
    begin
      @(posedge aclk);
      req_valid <= 1'b1;
      {req_fetch, req_write} <= op;
      {req_addr, req_wdata} <= {a, d};
      {process_controls_user_mode, req_cacheable} <= {u, c};
      #1 o[3] = ext_req_valid;
      @(posedge aclk);
      req_valid <= 1'b0;
      // Released lines carry the inverse so stale values cannot pass.
      {req_addr, req_wdata} <= ~{a, d};
      #1 o[2:0] = {rsp_valid, fault_a, unimplemented_operation_fault};
      rd = rsp_rdata;
    end
  endtask
endmodule // core_model

// File: tb/internal_data_ram_guard_tb.sv
`timescale 1ns/1ps
`include "data_ram_guard_regs.vh"
module internal_data_ram_guard_tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire req_valid, req_write, req_fetch, req_cacheable, rsp_valid, fault_a;
  wire process_controls_user_mode, unimplemented_operation_fault;
  wire [31:0] req_addr, req_wdata, rsp_rdata, s_axi_rdata;
  wire [3:0] req_strobe;
  wire ext_req_valid, dcache_req_valid, ext_req_cacheable, s_axi_rvalid;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  integer n_errors = 0;
  integer check_count = 0;
  integer i;
  reg [3:0] o;
  reg [31:0] rd;
  reg [1:0] r;
  localparam [1:0] ld = 2'h0, st = 2'h1, fe = 2'h2;
  localparam [1:0] sv = 2'h0, sc = 2'h1, us = 2'h2;
  localparam [3:0] ok = 4'h4, tf = 4'h6;
  always #50 aclk = ~aclk;
  internal_data_ram_guard internal_data_ram_guard_i (.*);
  core_model core_model_i (.*);
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task req(input [1:0] op, input [31:0] a, input [31:0] d, input [1:0] m,
      input [3:0] e);
    begin
      core_model_i.access(op, a, d, m[1], m[0], o, rd);
      chk({28'h0, o}, {28'h0, e});
    end
  endtask
  task axw(input [3:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task axr(input [3:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      s_axi_rready <= 1'b0;
    end
  endtask
  task t_supv;
    reg [31:0] a;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        a = (i == 0) ? 32'h10 : (i == 1) ? 32'h40 : 32'h3FC;
        req(st, a, ~a, sc, ok);
        req(ld, a, 32'h0, us, ok);
        chk(rd, ~a);
      end
    end
  endtask
  task t_user_low;
    begin
      req(st, 32'h3C, 32'h5A5A0F0F, sv, ok);
      req(st, 32'h3C, 32'h0, us, tf);
      req(ld, 32'h3C, 32'h0, us, ok);
      chk(rd, 32'h5A5A0F0F);
    end
  endtask
  task t_vec;
    begin
      axr(`OFF_BUS_CONTROL);
      chk(rd, `RST_BUS_CONTROL);
      axw(`OFF_FAULT_ADDR, 32'h1);
      chk({30'h0, r}, {30'h0, `RESP_SLVERR});
      axw(`OFF_BUS_CONTROL, 32'h1 << `BIT_SUPV_VEC_WP);
      req(st, 32'h0, 32'h1, sv, tf);
      req(st, 32'h40, 32'h2, sv, ok);
      req(st, 32'h44, 32'h2, us, ok);
      axw(`OFF_BUS_CONTROL, 32'h0);
      req(st, 32'h0, 32'h3, sv, ok);
    end
  endtask
  task t_user_prot;
    begin
      axw(`OFF_BUS_CONTROL, 32'h1 << `BIT_USER_RAM_WP);
      req(st, 32'h40, 32'h7, us, tf);
      req(st, 32'h3FC, 32'h7, us, tf);
      req(st, 32'h200, 32'h7, sv, ok);
      axw(`OFF_BUS_CONTROL, 32'h0);
      req(st, 32'h48, 32'h8, us, ok);
      req(ld, 32'h3FC, 32'h0, us, ok);
      chk(rd, ~32'h3FC);
    end
  endtask
  task t_fetch;
    begin
      req(fe, 32'h3FC, 32'h0, sv, 4'h5);
      req(fe, 32'h400, 32'h0, sv, 4'h8);
      req(st, 32'h400, 32'h0, sc, 4'h8);
      // Both sticky fault bits are set by now; the last fault was the fetch.
      axr(`OFF_STATUS);
      chk(rd, 32'h3);
      axr(`OFF_FAULT_ADDR);
      chk(rd, 32'h3FC);
      axw(`OFF_STATUS, 32'h3);
      axr(`OFF_STATUS);
      chk(rd, 32'h0);
    end
  endtask
  task t_endian;
    begin
      axr(`OFF_MEM_CONFIG);
      chk(rd, `RST_MEM_CONFIG);
      axw(`OFF_MEM_CONFIG, 32'h1 << `BIT_BIG_ENDIAN);
      req(st, 32'h80, 32'h11223344, sv, ok);
      req(ld, 32'h80, 32'h0, sv, ok);
      chk(rd, 32'h11223344);
      axw(`OFF_MEM_CONFIG, 32'h0);
      req(ld, 32'h80, 32'h0, sv, ok);
      chk(rd, 32'h44332211);
    end
  endtask
  task complete_run;
    begin
      $display("Checks %0d, errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_supv;
    t_user_low;
    t_vec;
    t_user_prot;
    t_fetch;
    t_endian;
    complete_run;
  end
  // The whole run needs about a hundred cycles; this allows ten thousand.
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    complete_run;
  end
endmodule // internal_data_ram_guard_tb
